/* File: core/sfoc_pkg.sv */
// Function
// - A status indicator mirrors one chosen input, safety output or logic node.
// - Test-pulse outputs check the inputs for shorts, each one serving at most four inputs.
// - Every safety output gets a dip self-test every 20 ms (basic) or 600 ms (extended).
// - The dip forces the output under test off for less than 120 us, then restores it.
// - A wrong readback at the end of any dip slot latches a fail state and turns every output off.
// - Four outputs group as four singles, two duals, or one dual plus two singles.
// - Only the grouping setting makes a dual channel; singles stay independent.
// - Automatic restart: an output is on only while its restart feedback is high.
// - Manual restart: an output turns on on a low-to-high feedback edge while demanded.
// - Monitored restart: an output turns on only after a low-high-low feedback pulse.
// - Each relay feedback contact is checked against the relay command.
// - An output with a relay expansion reports 12 ms more response time.
// - The basic variant runs only while both controller enables are high.
package sfoc_pkg;
  localparam int CLK_NS = 20;
  localparam int DIP_MAX_NS = 120000;
  localparam int DIP_CYC = DIP_MAX_NS / CLK_NS - 1;
  localparam int PER_BASIC_MS = 20;
  localparam int PER_EXT_MS = 600;
  localparam int PER_BASIC_CYC = PER_BASIC_MS * 1000000 / CLK_NS;
  localparam int PER_EXT_CYC = PER_EXT_MS * 1000000 / CLK_NS;
  localparam int RELAY_MS = 12;
  localparam int RELAY_CYC = RELAY_MS * 1000000 / CLK_NS;
  localparam int DEB_US = 200;
  localparam int DEB_CYC = DEB_US * 1000 / CLK_NS;
  localparam int IN_PER_TEST = 4;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SEL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_RESP = 8'h14;
  localparam logic [7:0] OFS_IN_FAULT = 8'h18;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SEL_RST = 32'h0000_0000;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  // Interrupt status bits
  localparam int IRQ_FAIL = 0;
  localparam int IRQ_RELAY = 1;
  localparam int IRQ_INPUT = 2;
  localparam int IRQ_DIP = 3;
  typedef enum logic [1:0] {GRP_SINGLE4 = 2'b00, GRP_DUAL2 = 2'b01, GRP_MIXED = 2'b10} sfoc_grp_type;
  typedef enum logic [1:0] {RM_AUTO = 2'b00, RM_MANUAL = 2'b01, RM_MONITOR = 2'b10} sfoc_rmode_type;
  typedef enum logic [1:0] {RS_OFF = 2'b00, RS_ARMED = 2'b01, RS_ON = 2'b10} sfoc_rst_type;
  typedef enum logic [1:0] {SRC_INPUT = 2'b00, SRC_OUTPUT = 2'b01, SRC_NODE = 2'b10} sfoc_src_type;
  // Control register layout, bit 31 down to 0
  typedef struct packed {
    logic [15:0] rsv;
    logic [3:0] relay_att;
    logic [7:0] rmode;
    logic [1:0] group;
    logic rsv1;
    logic ext;
  } sfoc_ctrl_type;
endpackage : sfoc_pkg

/* File: core/sfoc_top.sv */
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module sfoc_top #(
  parameter int N_IN = 8,
  parameter int N_TEST = 2,
  parameter int N_NODE = 16,
  parameter int PER_BASIC = sfoc_pkg::PER_BASIC_CYC,
  parameter int PER_EXT = sfoc_pkg::PER_EXT_CYC,
  parameter int DIP = sfoc_pkg::DIP_CYC,
  parameter int DEB = sfoc_pkg::DEB_CYC,
  parameter int RELAY = sfoc_pkg::RELAY_CYC,
  parameter logic [7:0] RESP_BASE_MS = 8'h0B
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic controller_enable_a,
  input wire logic controller_enable_b,
  input wire logic [N_IN-1:0] safety_in,
  input wire logic [N_NODE-1:0] logic_node,
  input wire logic [3:0] logic_demand,
  input wire logic [3:0] restart_fbk,
  input wire logic [3:0] output_readback,
  input wire logic [3:0] relay_fbk_closed,
  output logic [3:0] safety_switching_output,
  output logic [N_TEST-1:0] test_pulse_out,
  output logic status_out,
  output logic irq
);
  localparam int NS = N_IN + 14;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [NS-1:0] sync1_q, sync2_q;
  logic en_a_s, en_b_s;
  logic [3:0] fbk_s, rb_s, rly_s;
  logic [N_IN-1:0] in_s;
  // First stage feeds only the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {controller_enable_a, controller_enable_b, restart_fbk, output_readback, relay_fbk_closed, safety_in};
      sync2_q <= sync1_q;
    end
  end
  assign {en_a_s, en_b_s, fbk_s, rb_s, rly_s, in_s} = sync2_q;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  sfoc_pkg::sfoc_ctrl_type ctrl_q;
  logic [31:0] sel_q;
  logic [3:0] irq_stat_q, irq_mask_q, irq_evt;
  logic [N_IN-1:0] in_fault_q, in_fault_evt;
  logic aw_hold_q, w_hold_q, wr_go;
  logic [7:0] awaddr_q, araddr;
  logic [31:0] wdata_q, rdata_d;
  logic [3:0] wstrb_q;
  logic rd_ok;
  logic fail_q;
  logic [3:0] ssout_q;

  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_hold_q && w_hold_q;
  assign araddr = s_axi_araddr;

  // Address and data may arrive in either order
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q > sfoc_pkg::OFS_IN_FAULT || awaddr_q[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        old[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return old;
  endfunction : merge

  // Writable configuration
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= sfoc_pkg::CTRL_RST;
      sel_q <= sfoc_pkg::SEL_RST;
      irq_mask_q <= sfoc_pkg::IRQ_MASK_RST;
    end else if (wr_go) begin
      if (awaddr_q == sfoc_pkg::OFS_CTRL) ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
      if (awaddr_q == sfoc_pkg::OFS_SEL) sel_q <= merge(sel_q, wdata_q, wstrb_q);
      if (awaddr_q == sfoc_pkg::OFS_IRQ_MASK && wstrb_q[0]) irq_mask_q <= wdata_q[3:0];
    end
  end

  // Sticky events; a new event wins over a clearing write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= 4'h0;
      in_fault_q <= '0;
    end else begin
      if (wr_go && awaddr_q == sfoc_pkg::OFS_IRQ_STAT && wstrb_q[0]) begin
        irq_stat_q <= (irq_stat_q & ~wdata_q[3:0]) | irq_evt;
      end else begin
        irq_stat_q <= irq_stat_q | irq_evt;
      end
      if (wr_go && awaddr_q == sfoc_pkg::OFS_IN_FAULT) begin
        in_fault_q <= (in_fault_q & ~wdata_q[N_IN-1:0]) | in_fault_evt;
      end else begin
        in_fault_q <= in_fault_q | in_fault_evt;
      end
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // Read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (araddr)
      sfoc_pkg::OFS_CTRL: rdata_d = ctrl_q;
      sfoc_pkg::OFS_SEL: rdata_d = sel_q;
      sfoc_pkg::OFS_STATUS: rdata_d = {24'h000000, 1'b0, en_a_s && en_b_s, 1'b0, fail_q, ssout_q};
      sfoc_pkg::OFS_IRQ_STAT: rdata_d = {28'h0000000, irq_stat_q};
      sfoc_pkg::OFS_IRQ_MASK: rdata_d = {28'h0000000, irq_mask_q};
      sfoc_pkg::OFS_RESP: begin
        for (int k = 0; k < 4; k++) begin
          rdata_d[8*k +: 8] = RESP_BASE_MS + (ctrl_q.relay_att[k] ? 8'(sfoc_pkg::RELAY_MS) : 8'h00);
        end
      end
      sfoc_pkg::OFS_IN_FAULT: rdata_d[N_IN-1:0] = in_fault_q;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Restart feedback debounce and sequences
  // ----------------------------------------
  logic [3:0] fbk_deb_q, fbk_prev_q, fbk_rise, fbk_fall, chan_on;
  logic [31:0] deb_cnt_q [4];
  sfoc_pkg::sfoc_rst_type st_q [4];
  logic run;

  // Dual pairs are led by the even output of the pair
  function automatic logic [1:0] lead(input logic [1:0] grp, input logic [1:0] k);
    logic dual;
    dual = (grp == sfoc_pkg::GRP_DUAL2) || (grp == sfoc_pkg::GRP_MIXED && !k[1]);
    return dual ? {k[1], 1'b0} : k;
  endfunction : lead

  for (genvar k = 0; k < 4; k++) begin : g_chan
    sfoc_pkg::sfoc_rmode_type mode;
    assign mode = sfoc_pkg::sfoc_rmode_type'(ctrl_q.rmode[2*k +: 2]);
    assign fbk_rise[k] = fbk_deb_q[k] && !fbk_prev_q[k];
    assign fbk_fall[k] = !fbk_deb_q[k] && fbk_prev_q[k];
    // Level must hold DEB cycles, so one bounce cannot fake an edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        deb_cnt_q[k] <= 0;
        fbk_deb_q[k] <= 1'b0;
        fbk_prev_q[k] <= 1'b0;
      end else begin
        fbk_prev_q[k] <= fbk_deb_q[k];
        if (fbk_s[k] == fbk_deb_q[k]) begin
          deb_cnt_q[k] <= 0;
        end else if (deb_cnt_q[k] >= DEB - 1) begin
          deb_cnt_q[k] <= 0;
          fbk_deb_q[k] <= fbk_s[k];
        end else begin
          deb_cnt_q[k] <= deb_cnt_q[k] + 1;
        end
      end
    end
    // Restart interlock per channel
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        st_q[k] <= sfoc_pkg::RS_OFF;
      end else if (!run || !logic_demand[k]) begin
        st_q[k] <= sfoc_pkg::RS_OFF;
      end else begin
        unique case (st_q[k])
          sfoc_pkg::RS_OFF: begin
            if (mode == sfoc_pkg::RM_AUTO && fbk_deb_q[k]) st_q[k] <= sfoc_pkg::RS_ON;
            else if (mode == sfoc_pkg::RM_MANUAL && fbk_rise[k]) st_q[k] <= sfoc_pkg::RS_ON;
            else if (mode == sfoc_pkg::RM_MONITOR && fbk_rise[k]) st_q[k] <= sfoc_pkg::RS_ARMED;
          end
          sfoc_pkg::RS_ARMED: begin
            if (fbk_fall[k]) st_q[k] <= sfoc_pkg::RS_ON;
          end
          sfoc_pkg::RS_ON: begin
            if (mode == sfoc_pkg::RM_AUTO && !fbk_deb_q[k]) st_q[k] <= sfoc_pkg::RS_OFF;
          end
          default: st_q[k] <= sfoc_pkg::RS_OFF;
        endcase
      end
    end
    assign chan_on[k] = st_q[lead(ctrl_q.group, 2'(k))] == sfoc_pkg::RS_ON;
  end

  // ----------------------------------------
  // Voltage-dip self-test and test pulses
  // ----------------------------------------
  logic [31:0] per_cnt_q, dip_cnt_q, per_reload;
  logic dip_act_q, dip_start, dip_sample;
  logic [1:0] dip_idx_q;
  logic [3:0] exp1_q, exp2_q, rb_bad;

  assign per_reload = ctrl_q.ext ? PER_EXT : PER_BASIC;
  assign dip_start = !dip_act_q && per_cnt_q == 0;
  assign dip_sample = dip_act_q && dip_cnt_q == DIP - 1;
  // One output at a time, so a short to a neighbour shows up
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_q <= 0;
      dip_cnt_q <= 0;
      dip_act_q <= 1'b0;
      dip_idx_q <= 2'b00;
    end else if (dip_start) begin
      per_cnt_q <= per_reload - 1;
      dip_act_q <= 1'b1;
      dip_idx_q <= 2'b00;
      dip_cnt_q <= 0;
    end else if (dip_act_q) begin
      dip_cnt_q <= dip_sample ? 0 : dip_cnt_q + 1;
      if (dip_sample) begin
        dip_idx_q <= dip_idx_q + 2'b01;
        dip_act_q <= dip_idx_q != 2'b11;
      end
      per_cnt_q <= per_cnt_q - 1;
    end else begin
      per_cnt_q <= per_cnt_q - 1;
    end
  end

  // Each test line drives low only in its own dip slot
  for (genvar t = 0; t < N_TEST; t++) begin : g_test
    assign test_pulse_out[t] = !(dip_act_q && dip_idx_q == 2'(t));
  end
  for (genvar i = 0; i < N_IN; i++) begin : g_in
    // An input still high while its test line is low is shorted
    assign in_fault_evt[i] = dip_sample && !test_pulse_out[i / sfoc_pkg::IN_PER_TEST] && in_s[i];
  end

  // Expected level delayed to line up with the synchronised readback
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      exp1_q <= 4'h0;
      exp2_q <= 4'h0;
    end else begin
      exp1_q <= ssout_q;
      exp2_q <= exp1_q;
    end
  end
  assign rb_bad = dip_sample ? (rb_s ^ exp2_q) : 4'h0;

  // ----------------------------------------
  // Fail latch, outputs, relays, indicator
  // ----------------------------------------
  logic [31:0] rly_cnt_q;
  logic [3:0] rly_cmd_q, rly_mis;
  logic rly_fault;

  assign run = !fail_q && (ctrl_q.ext || (en_a_s && en_b_s));
  // Cleared only by reset: a fail must not recover by itself
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fail_q <= 1'b0;
    end else if (|rb_bad) begin
      fail_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ssout_q <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        ssout_q[k] <= run && chan_on[k] && !(dip_act_q && dip_idx_q == 2'(k));
      end
    end
  end
  assign safety_switching_output = ssout_q;

  // Closed NC contact with relay energised is a mismatch; allow the relay its switching time
  assign rly_mis = ctrl_q.relay_att & ~(ssout_q ^ rly_s);
  assign rly_fault = |rly_mis && rly_cnt_q == RELAY - 1;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rly_cmd_q <= 4'h0;
      rly_cnt_q <= 0;
    end else begin
      rly_cmd_q <= ssout_q;
      if (rly_cmd_q != ssout_q || !(|rly_mis)) rly_cnt_q <= 0;
      else if (rly_cnt_q < RELAY - 1) rly_cnt_q <= rly_cnt_q + 1;
    end
  end

  assign irq_evt = {dip_sample && dip_idx_q == 2'b11, |in_fault_evt, rly_fault, |rb_bad && !fail_q};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_out <= 1'b0;
    end else begin
      unique case (sfoc_pkg::sfoc_src_type'(sel_q[1:0]))
        sfoc_pkg::SRC_INPUT: status_out <= in_s[sel_q[7:4] % N_IN];
        sfoc_pkg::SRC_OUTPUT: status_out <= ssout_q[sel_q[5:4]];
        sfoc_pkg::SRC_NODE: status_out <= logic_node[sel_q[7:4] % N_NODE];
        default: status_out <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_fail_all_off: assert property (fail_q |=> ssout_q == 4'h0) else $error("outputs on after fail");
  a_readback_latch: assert property (|rb_bad |=> fail_q [*3]) else $error("fail not latched");
  a_dip_forces_low: assert property (dip_act_q |=> !ssout_q[$past(dip_idx_q)]) else $error("dip not low");
  a_dip_width: assert property ($rose(dip_act_q) |-> dip_cnt_q == 0 ##1 dip_cnt_q == 1) else $error("dip count");
  a_dip_period: assert property (dip_start |=> per_cnt_q == $past(per_reload) - 1) else $error("period reload");
  a_enable_gate: assert property (!ctrl_q.ext && !en_a_s |=> ssout_q == 4'h0) else $error("enable ignored");
  a_auto_fbk: assert property (ctrl_q.group == 2'b00 && ctrl_q.rmode[1:0] == 2'b00 && !fbk_deb_q[0]
    |=> ##1 !ssout_q[0] || fbk_deb_q[0] || $past(fbk_deb_q[0])) else $error("auto without feedback");
  a_manual_edge: assert property (st_q[0] == sfoc_pkg::RS_OFF && ctrl_q.rmode[1:0] == 2'b01 && !fbk_rise[0]
    |=> st_q[0] != sfoc_pkg::RS_ON) else $error("manual on without edge");
  a_monitor_seq: assert property (st_q[0] == sfoc_pkg::RS_OFF && ctrl_q.rmode[1:0] == 2'b10
    |=> st_q[0] != sfoc_pkg::RS_ON) else $error("monitored skipped pulse");
  a_relay_flag: assert property (rly_fault |=> irq_stat_q[sfoc_pkg::IRQ_RELAY]) else $error("relay flag lost");
  a_status_mirror: assert property (sel_q[1:0] == 2'b01 && $stable(sel_q)
    |=> status_out == $past(ssout_q[sel_q[5:4]])) else $error("indicator wrong");
  a_dual_follow: assert property (ctrl_q.group == sfoc_pkg::GRP_DUAL2 && !dip_act_q
    |=> ssout_q[1] == ssout_q[0]) else $error("dual split");
  c_dip_round: cover property (dip_sample && dip_idx_q == 2'b11);
  c_fail_entry: cover property ($rose(fail_q));
  c_monitor_on: cover property (st_q[0] == sfoc_pkg::RS_ARMED ##[1:1000] st_q[0] == sfoc_pkg::RS_ON);
endmodule : sfoc_top

/* File: testbench/safety_output_control_tb.sv */
`timescale 1ns/10ps
module safety_output_control_tb;
  localparam int PB = 200;
  localparam int PE = 400;
  localparam int DP = 8;
  logic clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic controller_enable_a, controller_enable_b, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, status_out, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, in_stuck, safety_in;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd;
  logic [3:0] s_axi_wstrb, logic_demand, btn, rb_lo, rly_st, ssw, restart_fbk, output_readback, relay_fbk_closed;
  logic [1:0] s_axi_bresp, s_axi_rresp, test_pulse_out, rsp;
  logic [15:0] logic_node;
  int num_errors, compares, n;

  sfoc_top #(.PER_BASIC(PB), .PER_EXT(PE), .DIP(DP), .DEB(4), .RELAY(20)) sfoc_top_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .controller_enable_a(controller_enable_a), .controller_enable_b(controller_enable_b),
    .safety_in(safety_in), .logic_node(logic_node), .logic_demand(logic_demand), .restart_fbk(restart_fbk),
    .output_readback(output_readback), .relay_fbk_closed(relay_fbk_closed), .safety_switching_output(ssw),
    .test_pulse_out(test_pulse_out), .status_out(status_out), .irq(irq));
  sfoc_plant sfoc_plant_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ssw(ssw), .btn(btn), .rb_lo(rb_lo),
    .rly_st(rly_st), .output_readback(output_readback), .relay_fbk_closed(relay_fbk_closed),
    .restart_fbk(restart_fbk));
  // Inputs echo their own test line, four per line; a stuck mask marks a short
  assign safety_in = {{4{test_pulse_out[1]}}, {4{test_pulse_out[0]}}} | in_stuck;

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // -------------------------------------------------
  // Helpers and reference model
  // -------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // Expected outputs in auto mode, enabled, feedback high; even output leads a dual pair
  function automatic logic [3:0] exp_out(input int g, input logic [3:0] d);
    if (g == 1) return {d[2], d[2], d[0], d[0]};
    if (g == 2) return {d[3], d[2], d[0], d[0]};
    return d;
  endfunction : exp_out
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  // Write holds each channel until its own ready, bready until bvalid
  // No local limit: a hung slave is caught by the watchdog and counted
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  // Edges until test line 0 falls; a dead dip engine runs into the watchdog
  task automatic wait_dip(output int c);
    c = 0;
    @(posedge clk_sys);
    while (test_pulse_out[0] !== 1'b1) begin
      @(posedge clk_sys);
      c++;
    end
    while (test_pulse_out[0] !== 1'b0) begin
      @(posedge clk_sys);
      c++;
    end
  endtask : wait_dip
  // Park well clear of a dip round so outputs show their channel state
  task automatic wait_quiet();
    int k;
    wait_dip(k);
    repeat (4 * DP + 6) @(posedge clk_sys);
  endtask : wait_quiet

  initial begin
    repeat (40000) @(posedge clk_sys);
    num_errors++;
    tally_and_finish();
  end
  // -------------------------------------------------
  // Main sequence
  // -------------------------------------------------
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, in_stuck, logic_node, rb_lo, rly_st} = 80'h0;
    {controller_enable_a, controller_enable_b} = 2'b11;
    {s_axi_wstrb, logic_demand, btn} = 12'hFFF;
    seed = 32'hAC40;
    num_errors = 0;
    compares = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    axr(sfoc_pkg::OFS_CTRL);
    chk("ctrl_rst", rd, sfoc_pkg::CTRL_RST);
    axr(sfoc_pkg::OFS_SEL);
    chk("sel_rst", rd, sfoc_pkg::SEL_RST);
    axr(sfoc_pkg::OFS_IRQ_MASK);
    chk("mask_rst", rd, 32'(sfoc_pkg::IRQ_MASK_RST));
    axr(8'h1C);
    chk("rd_unmapped", 32'(rsp), 32'h2);
    axw(8'h1C, 32'hFFFF_FFFF);
    chk("wr_unmapped", 32'(rsp), 32'h2);
    // Groupings with a sparse demand pattern
    for (int g = 0; g < 3; g++) begin
      axw(sfoc_pkg::OFS_CTRL, 32'(g) << 2);
      logic_demand <= 4'b0101;
      wait_quiet();
      chk("group_out", 32'(ssw), 32'(exp_out(g, 4'b0101)));
    end
    axw(sfoc_pkg::OFS_CTRL, 32'h0);
    logic_demand <= 4'hF;
    btn <= 4'b1011;
    wait_quiet();
    chk("auto_fbk", 32'(ssw), 32'h0B);
    btn <= 4'hF;
    wait_dip(n);
    wait_dip(n);
    chk("period_basic", 32'(n + 1), 32'(PB));
    n = 0;
    repeat (16) begin
      @(posedge clk_sys);
      if (ssw[0] === 1'b0) n++;
    end
    chk("dip_width", 32'(n), 32'(DP));
    axw(sfoc_pkg::OFS_CTRL, 32'h1);
    repeat (3) wait_dip(n);
    chk("period_ext", 32'(n + 1), 32'(PE));
    // Indicator mirrors a random node, then an output
    axw(sfoc_pkg::OFS_SEL, 32'h52);
    repeat (6) begin
      seed = xs(seed);
      logic_node <= seed[15:0];
      repeat (4) @(posedge clk_sys);
      chk("status_node", 32'(status_out), 32'(logic_node[5]));
    end
    axw(sfoc_pkg::OFS_SEL, 32'h21);
    wait_quiet();
    chk("status_output", 32'(status_out), 32'(ssw[2]));
    // Input 5 follows test line 1, so it reads low inside the second dip slot
    axw(sfoc_pkg::OFS_SEL, 32'h50);
    wait_dip(n);
    repeat (13) @(posedge clk_sys);
    chk("status_input", 32'(status_out), 32'h0);
    axr(sfoc_pkg::OFS_IN_FAULT);
    chk("in_fault_clean", rd, 32'h0);
    in_stuck <= 8'h20;
    wait_quiet();
    axr(sfoc_pkg::OFS_IN_FAULT);
    chk("in_fault_short", rd, 32'h20);
    in_stuck <= 8'h00;
    // Manual on output 0, monitored on output 1; a one-cycle bounce must not count
    // Demand drops for outputs 0 and 1 across the mode change so neither keeps its auto state
    btn <= 4'b1100;
    logic_demand <= 4'hC;
    axw(sfoc_pkg::OFS_CTRL, 32'h90);
    logic_demand <= 4'hF;
    btn <= 4'b1101;
    @(posedge clk_sys);
    btn <= 4'b1100;
    wait_quiet();
    chk("bounce_off", 32'(ssw[1:0]), 32'h0);
    btn <= 4'hF;
    wait_quiet();
    chk("manual_rise", 32'(ssw[1:0]), 32'h1);
    btn <= 4'b1101;
    wait_quiet();
    chk("monitor_fall", 32'(ssw[1:0]), 32'h3);
    btn <= 4'hF;
    // Relay expansion on output 3
    axw(sfoc_pkg::OFS_CTRL, 32'h8000);
    axr(sfoc_pkg::OFS_RESP);
    chk("resp_time", rd, 32'h0B0B_0B0B + (32'(sfoc_pkg::RELAY_MS) << 24));
    rly_st <= 4'h8;
    repeat (250) @(posedge clk_sys);
    axr(sfoc_pkg::OFS_IRQ_STAT);
    chk("relay_mismatch", 32'(rd[1]), 32'h1);
    chk("irq_masked", 32'(irq), 32'h0);
    rly_st <= 4'h0;
    repeat (40) @(posedge clk_sys);
    axw(sfoc_pkg::OFS_IRQ_STAT, 32'h2);
    axr(sfoc_pkg::OFS_IRQ_STAT);
    chk("relay_clear", 32'(rd[1]), 32'h0);
    // Enables gate the basic variant only
    axw(sfoc_pkg::OFS_CTRL, 32'h0);
    controller_enable_a <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk("disabled", 32'(ssw), 32'h0);
    axw(sfoc_pkg::OFS_CTRL, 32'h1);
    wait_quiet();
    chk("ext_enabled", 32'(ssw), 32'hF);
    controller_enable_a <= 1'b1;
    // Readback fault latches the safe state
    axw(sfoc_pkg::OFS_IRQ_MASK, 32'h1);
    chk("irq_idle", 32'(irq), 32'h0);
    rb_lo <= 4'b0100;
    repeat (450) @(posedge clk_sys);
    chk("fail_out", 32'(ssw), 32'h0);
    chk("irq_fail", 32'(irq), 32'h1);
    axr(sfoc_pkg::OFS_STATUS);
    chk("fail_flag", 32'(rd[4]), 32'h1);
    rb_lo <= 4'h0;
    axw(sfoc_pkg::OFS_IRQ_STAT, 32'h1);
    repeat (450) @(posedge clk_sys);
    chk("irq_cleared", 32'(irq), 32'h0);
    chk("fail_latched", 32'(ssw), 32'h0);
    tally_and_finish();
  end
endmodule : safety_output_control_tb

/* File: testbench/sfoc_plant.sv */
`timescale 1ns/10ps
// -------------------------------------------------
// Contactors, relays and restart buttons
// -------------------------------------------------
module sfoc_plant (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] ssw,
  input wire logic [3:0] btn,
  input wire logic [3:0] rb_lo,
  input wire logic [3:0] rly_st,
  output logic [3:0] output_readback,
  output logic [3:0] relay_fbk_closed,
  output logic [3:0] restart_fbk
);
  // Sensed output wire; a commanded wiring fault pins it low
  assign output_readback = ssw & ~rb_lo;
  // NC feedback opens one cycle after the coil pulls in; welded contact stays closed
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      relay_fbk_closed <= 4'hF;
    end else begin
      relay_fbk_closed <= ~ssw | rly_st;
    end
  end
  // Button wired straight to the restart feedback input
  assign restart_fbk = btn;
endmodule : sfoc_plant
